// file: pkg/actdm_pkg.sv
package actdm_pkg;
    // frame geometry
    localparam int unsigned SLOT_BITS     = 16;
    localparam int unsigned SLOTS         = 16;
    localparam logic [3:0]  LAST_BIT      = 4'hf;
    localparam logic [3:0]  SLOT14        = 4'he;
    localparam logic [4:0]  RX_COUNT      = 5'h05;
    localparam logic [4:0]  TX7_COUNT     = 5'h07;
    localparam logic [4:0]  TX16_COUNT    = 5'h10;
    // channel masks
    localparam logic [15:0] RX_MASK_RST   = 16'h001f;
    localparam logic [15:0] TX7_MASK      = 16'h007f;
    localparam logic [15:0] TX16_MASK     = 16'hffff;
    localparam logic [15:0] TX_MASK_RST   = 16'h001f;
    // setup words
    localparam logic [15:0] TAG_SETUP     = 16'he000;
    localparam logic [15:0] CFG_ADDR      = 16'h7400;
    localparam logic [15:0] CFG_DATA      = 16'hff80;
    // register offsets
    localparam logic [5:0]  A_CTRL        = 6'h00;
    localparam logic [5:0]  A_RXMASK      = 6'h01;
    localparam logic [5:0]  A_TXMASK      = 6'h02;
    localparam logic [5:0]  A_STATUS      = 6'h03;
    localparam logic [5:0]  A_TXBUF       = 6'h10;
    localparam logic [5:0]  A_RXBUF       = 6'h20;
    // interrupt vectoring latency
    localparam logic [2:0]  IRQ_LAT       = 3'h4;
    // link clock frequency in MHz
    localparam real         BCLK_MHZ      = 12.288;
endpackage

// file: rtl/actdm_engine.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
// What the document requires of this block and its host
// RL1 - each slot is sixteen bits on the serial bit clock
// RL2 - host sends tag word e000 during setup
// RL3 - host sends config address 7400 and data ff80 during setup
// RL4 - unused transmit slots carry zero words
// RL5 - receive mask 0000001f takes slots 0-4 into five-word buffer
// RL6 - seven-slot option: mask 0000007f, count 7, slots 5-6 zero
// RL7 - sixteen-slot option: mask 0000ffff, count 16, zeros in 5-15
// RL8 - per-frame count equals enabled channels; completion fires at zero
// RL9 - receive request one clock after last enabled word shifted in
// RL10 - vectoring waits four cycles after the request
// RL11 - sixteen-slot option fetches next tag after slot 14 sent
// RL12 - host has ten slots after receive irq to update tag
// RL13 - short buffers move tag to holding register a slot early
// RL14 - host must avoid writing tag too late
// RL15 - host writes tag within 74 cycles of transmit irq
// RL16 - host puts left audio in slot 3, right in 4
// RL17 - host polls valid or request bits below 48 kHz
// RL18 - buffer data leaves starting at next frame sync
// RL19 - five-slot receive irq after slot 4, tx continues through 15
// RL20 - host may process at 48 kHz with tags always set
// RL21 - host passes flags between handlers in memory
// RL22 - frame sync marks slot 0; slots follow in order
module actdm_engine (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // serial link
    input  wire logic        bit_clk,
    input  wire logic        frame_sync,
    input  wire logic        sdata_in,
    output logic             sdata_out,
    // interrupt requests and vector entry
    output logic             rx_irq,
    output logic             tx_irq,
    output logic             rx_vector,
    output logic             tx_vector
);
    // storage
    logic [15:0] tx_buf [0:15];
    logic [15:0] rx_buf [0:4];
    logic [15:0] rx_channel_enable_mask_reg;
    logic [15:0] tx_channel_enable_mask_reg;
    logic        multichannel_tdm_operation_reg;
    logic        serial_tx_irq_enable_reg;
    logic        serial_rx_irq_enable_reg;
    logic [15:0] tx_holding_register_reg;
    logic [15:0] tx_shift_reg;
    logic [15:0] rx_shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic [3:0]  slot_reg;
    logic        in_frame_reg;
    logic [4:0]  tx_count_reg;
    logic [4:0]  rx_count_reg;
    logic [4:0]  tx_ptr_reg;
    logic [2:0]  rx_ptr_reg;
    logic        rx_done_reg;
    logic        tx_done_reg;
    logic [2:0]  rx_lat_reg;
    logic [2:0]  tx_lat_reg;
    logic        rx_pend_reg;
    logic        tx_pend_reg;

    // synchronisers for link inputs
    logic [1:0] bclk_sync_reg;
    logic [1:0] fs_sync_reg;
    logic [1:0] din_sync_reg;
    logic       bclk_prev_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            bclk_sync_reg <= 2'h0;
            fs_sync_reg   <= 2'h0;
            din_sync_reg  <= 2'h0;
            bclk_prev_reg <= 1'b0;
        end else begin
            bclk_sync_reg <= {bclk_sync_reg[0], bit_clk};
            fs_sync_reg   <= {fs_sync_reg[0], frame_sync};
            din_sync_reg  <= {din_sync_reg[0], sdata_in};
            bclk_prev_reg <= bclk_sync_reg[1];
        end
    end

    // bit clock edges: drive on rising, sample on falling
    logic rise;
    logic fall;
    assign rise = bclk_sync_reg[1] & ~bclk_prev_reg;
    assign fall = ~bclk_sync_reg[1] & bclk_prev_reg;

    // slot position decode
    logic       fs_start;
    logic       word_end;
    logic       rx_en_slot;
    logic       tx_en_slot;
    logic [4:0] rx_target;
    logic [4:0] tx_target;
    assign fs_start   = rise & fs_sync_reg[1] & multichannel_tdm_operation_reg;
    assign word_end   = in_frame_reg & (bit_cnt_reg == actdm_pkg::LAST_BIT);
    assign rx_en_slot = rx_channel_enable_mask_reg[slot_reg];
    assign tx_en_slot = tx_channel_enable_mask_reg[slot_reg + 4'h1];
    assign rx_target  = (rx_channel_enable_mask_reg == actdm_pkg::RX_MASK_RST)
                        ? actdm_pkg::RX_COUNT : actdm_pkg::RX_COUNT;
    assign tx_target  = (tx_channel_enable_mask_reg == actdm_pkg::TX16_MASK)
                        ? actdm_pkg::TX16_COUNT
                        : (tx_channel_enable_mask_reg == actdm_pkg::TX7_MASK)
                        ? actdm_pkg::TX7_COUNT : actdm_pkg::RX_COUNT;

    // frame and bit counters
    always_ff @(posedge mclk) begin
        if (rst) begin
            in_frame_reg <= 1'b0;
            bit_cnt_reg  <= 4'h0;
            slot_reg     <= 4'h0;
        end else if (fs_start) begin
            in_frame_reg <= 1'b1; // [RL22]
            bit_cnt_reg  <= 4'h0;
            slot_reg     <= 4'h0;
        end else if (rise && in_frame_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1; // [RL1]
            if (word_end) begin
                slot_reg <= slot_reg + 4'h1;
                if (slot_reg == 4'hf)
                    in_frame_reg <= 1'b0;
            end
        end
    end

    // transmit shifter, loaded from holding register at each enabled slot start
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_shift_reg <= 16'h0000;
            sdata_out    <= 1'b0;
        end else if (fs_start || (rise && word_end && slot_reg != 4'hf)) begin
            // zero in slots outside the mask
            if (fs_start || tx_en_slot) begin
                tx_shift_reg <= {tx_holding_register_reg[14:0], 1'b0};
                sdata_out    <= tx_holding_register_reg[15]; // [RL18]
            end else begin
                tx_shift_reg <= 16'h0000;
                sdata_out    <= 1'b0; // [RL4]
            end
        end else if (rise && in_frame_reg) begin
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
            sdata_out    <= tx_shift_reg[15];
        end else if (rise) begin
            sdata_out <= 1'b0;
        end
    end

    // transmit dma: refill holding register one slot ahead
    logic tx_load;
    assign tx_load = fs_start
                     || (rise && word_end && slot_reg != 4'hf && tx_en_slot);
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_holding_register_reg <= actdm_pkg::TAG_SETUP;
            tx_ptr_reg              <= 5'h01;
            tx_count_reg            <= 5'h00;
            tx_done_reg             <= 1'b0;
        end else begin
            tx_done_reg <= 1'b0;
            if (fs_start)
                tx_count_reg <= tx_target - 5'h2; // [RL8] tag, word 1 out
            if (tx_load && tx_count_reg != 5'h00 && !fs_start)
                tx_count_reg <= tx_count_reg - 5'h1;
            if (tx_load && tx_count_reg == 5'h01 && !fs_start)
                tx_done_reg <= 1'b1; // [RL8]
            // fetch next word; after the final word, fetch next tag
            if (tx_load) begin
                if (tx_ptr_reg >= tx_target) begin
                    // [RL11] [RL13] tag fetched as last enabled slot starts
                    tx_holding_register_reg <= tx_buf[0];
                    tx_ptr_reg              <= 5'h01;
                end else begin
                    tx_holding_register_reg <= tx_buf[tx_ptr_reg[3:0]];
                    tx_ptr_reg              <= tx_ptr_reg + 5'h1; // [RL6] [RL7]
                end
            end
        end
    end

    // receive shifter and dma into five-word buffer
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_shift_reg <= 16'h0000;
            rx_ptr_reg   <= 3'h0;
            rx_count_reg <= 5'h00;
            rx_done_reg  <= 1'b0;
        end else begin
            rx_done_reg <= 1'b0;
            if (fs_start) begin
                rx_ptr_reg   <= 3'h0;
                rx_count_reg <= rx_target;
            end
            if (fall && in_frame_reg) begin
                rx_shift_reg <= {rx_shift_reg[14:0], din_sync_reg[1]};
                if (bit_cnt_reg == actdm_pkg::LAST_BIT && rx_en_slot
                    && rx_count_reg != 5'h00 && rx_ptr_reg < 3'h5) begin
                    rx_ptr_reg   <= rx_ptr_reg + 3'h1; // [RL5]
                    rx_count_reg <= rx_count_reg - 5'h1;
                    // [RL9] [RL19] request the cycle after the last word
                    if (rx_count_reg == 5'h01)
                        rx_done_reg <= 1'b1;
                end
            end
        end
    end

    // receive buffer writes
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_rx
            always_ff @(posedge mclk) begin
                if (rst)
                    rx_buf[gi] <= 16'h0000;
                else if (fall && in_frame_reg && rx_en_slot
                         && bit_cnt_reg == actdm_pkg::LAST_BIT
                         && rx_count_reg != 5'h00
                         && rx_ptr_reg == 3'(gi))
                    rx_buf[gi] <= {rx_shift_reg[14:0], din_sync_reg[1]};
            end
        end
    endgenerate

    // transmit buffer: setup words at reset, software writes after
    generate
        for (gi = 0; gi < 16; gi++) begin : g_tx
            always_ff @(posedge mclk) begin
                if (rst)
                    tx_buf[gi] <= (gi == 0) ? actdm_pkg::TAG_SETUP
                                : (gi == 1) ? actdm_pkg::CFG_ADDR
                                : (gi == 2) ? actdm_pkg::CFG_DATA
                                : 16'h0000;
                else if (reg_wr && reg_addr == actdm_pkg::A_TXBUF + 6'(gi))
                    tx_buf[gi] <= reg_wdata;
            end
        end
    endgenerate

    // control registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            multichannel_tdm_operation_reg <= 1'b0;
            serial_tx_irq_enable_reg       <= 1'b0;
            serial_rx_irq_enable_reg       <= 1'b0;
            rx_channel_enable_mask_reg     <= actdm_pkg::RX_MASK_RST;
            tx_channel_enable_mask_reg     <= actdm_pkg::TX_MASK_RST;
        end else if (reg_wr) begin
            if (reg_addr == actdm_pkg::A_CTRL) begin
                multichannel_tdm_operation_reg <= reg_wdata[0];
                serial_tx_irq_enable_reg       <= reg_wdata[1];
                serial_rx_irq_enable_reg       <= reg_wdata[2];
            end
            if (reg_addr == actdm_pkg::A_RXMASK)
                rx_channel_enable_mask_reg <= reg_wdata; // [RL5]
            if (reg_addr == actdm_pkg::A_TXMASK)
                tx_channel_enable_mask_reg <= reg_wdata; // [RL6] [RL7]
        end
    end

    // interrupt requests and vectoring latency
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_irq      <= 1'b0;
            tx_irq      <= 1'b0;
            rx_vector   <= 1'b0;
            tx_vector   <= 1'b0;
            rx_lat_reg  <= 3'h0;
            tx_lat_reg  <= 3'h0;
            rx_pend_reg <= 1'b0;
            tx_pend_reg <= 1'b0;
        end else begin
            rx_irq    <= rx_done_reg & serial_rx_irq_enable_reg; // [RL9]
            tx_irq    <= tx_done_reg & serial_tx_irq_enable_reg;
            rx_vector <= 1'b0;
            tx_vector <= 1'b0;
            if (rx_done_reg && serial_rx_irq_enable_reg) begin
                rx_pend_reg <= 1'b1;
                rx_lat_reg  <= 3'h1;
            end else if (rx_pend_reg) begin
                rx_lat_reg <= rx_lat_reg + 3'h1;
                if (rx_lat_reg == actdm_pkg::IRQ_LAT) begin
                    rx_vector   <= 1'b1; // [RL10]
                    rx_pend_reg <= 1'b0;
                end
            end
            if (tx_done_reg && serial_tx_irq_enable_reg) begin
                tx_pend_reg <= 1'b1;
                tx_lat_reg  <= 3'h1;
            end else if (tx_pend_reg) begin
                tx_lat_reg <= tx_lat_reg + 3'h1;
                if (tx_lat_reg == actdm_pkg::IRQ_LAT) begin
                    tx_vector   <= 1'b1; // [RL10]
                    tx_pend_reg <= 1'b0;
                end
            end
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= 16'h0000;
            if (reg_addr == actdm_pkg::A_CTRL)
                reg_rdata <= {13'h0000, serial_rx_irq_enable_reg,
                              serial_tx_irq_enable_reg,
                              multichannel_tdm_operation_reg};
            else if (reg_addr == actdm_pkg::A_RXMASK)
                reg_rdata <= rx_channel_enable_mask_reg;
            else if (reg_addr == actdm_pkg::A_TXMASK)
                reg_rdata <= tx_channel_enable_mask_reg;
            else if (reg_addr == actdm_pkg::A_STATUS)
                reg_rdata <= {3'h0, tx_count_reg, in_frame_reg,
                              3'h0, slot_reg};
            else if (reg_addr[5:4] == 2'h1)
                reg_rdata <= tx_buf[reg_addr[3:0]];
            else if (reg_addr[5:4] == 2'h2 && reg_addr[3:0] < 4'h5)
                reg_rdata <= rx_buf[reg_addr[2:0]];
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

// file: sim/actdm_codec_model.sv
`timescale 1ns/1ps
module actdm_codec_model (
    // control and serial return
    input  wire logic        run,
    input  wire logic        sdata_out,
    // link toward the engine
    output logic             bit_clk,
    output logic             frame_sync,
    output logic             sdata_in,
    // observation
    output logic [7:0]       pos,
    output logic [15:0]      txw [16]
);
    logic [15:0] sh;
    logic [15:0] w;
    logic        idle_t = 1'b0;
    int          k;

    // clock stands still while run is low, data line toggles there
    always begin
        bit_clk = 1'b0;
        frame_sync = 1'b0;
        idle_t = ~idle_t;
        sdata_in = idle_t;
        #16;
        while (run) begin
            for (k = 0; k < 256; k++) begin // 16 bits per slot
                sh = {sh[14:0], sdata_out};
                if (k[3:0] == 4'h0) txw[k[7:4] - 4'h1] = sh;
                w = 16'h9000 ^ {4{k[7:4]}};
                bit_clk = 1'b1;
                frame_sync = (k == 0); // marks slot 0
                sdata_in = w[~k[3:0]];
                pos = 8'(k + 1);
                #16;
                bit_clk = 1'b0;
                #16;
            end
        end
    end
endmodule

// file: sim/actdm_engine_assertions.sv
`timescale 1ns/1ps
module actdm_engine_assertions (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // register port
    input wire logic [5:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // serial link
    input wire logic        bit_clk,
    input wire logic        frame_sync,
    input wire logic        sdata_in,
    input wire logic        sdata_out,
    // interrupt requests
    input wire logic        rx_irq,
    input wire logic        tx_irq,
    input wire logic        rx_vector,
    input wire logic        tx_vector
);
    logic [11:0] rx_gap;
    logic [11:0] tx_gap;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // cycles since the last request, saturating
    always_ff @(posedge mclk) begin
        if (rst || rx_irq) rx_gap <= rst ? 12'hfff : 12'h000;
        else if (rx_gap != 12'hfff) rx_gap <= rx_gap + 12'h001;
    end
    always_ff @(posedge mclk) begin
        if (rst || tx_irq) tx_gap <= rst ? 12'hfff : 12'h000;
        else if (tx_gap != 12'hfff) tx_gap <= tx_gap + 12'h001;
    end

    a_rx_vec_delay:
        assert property (rx_irq |-> ##4 rx_vector)
        else $error("rx vector not four cycles after request");
    a_rx_vec_cause:
        assert property (rx_vector |-> $past(rx_irq, 4))
        else $error("rx vector without request");
    a_tx_vec_delay:
        assert property (tx_irq |-> ##4 tx_vector)
        else $error("tx vector not four cycles after request");
    a_tx_vec_cause:
        assert property (tx_vector |-> $past(tx_irq, 4))
        else $error("tx vector without request");
    a_rx_irq_pulse:
        assert property (rx_irq |=> !rx_irq)
        else $error("rx request longer than one cycle");
    a_rx_irq_gap:
        assert property (rx_irq |-> rx_gap > 12'h3e8)
        else $error("rx request twice in one frame");
    a_tx_irq_gap:
        assert property (tx_irq |-> tx_gap > 12'h3e8)
        else $error("tx request twice in one frame");
    a_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_sout_on_rise:
        assert property ($changed(sdata_out)
                         |-> $past(bit_clk) || $past(bit_clk, 2))
        else $error("serial out moved away from a clock rise");
endmodule

bind actdm_engine actdm_engine_assertions i_actdm_engine_assertions (
    .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bit_clk, .frame_sync, .sdata_in, .sdata_out,
    .rx_irq, .tx_irq, .rx_vector, .tx_vector
);

// file: sim/actdm_engine_test.sv
`timescale 1ns/1ps
module actdm_engine_test;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        run = 1'b0;
    logic [15:0] reg_rdata;
    logic        bit_clk, frame_sync, sdata_in, sdata_out;
    logic        rx_irq, tx_irq, rx_vector, tx_vector;
    logic [7:0]  pos;
    logic [15:0] txw [16];
    logic [15:0] tb_buf [16];
    logic [15:0] m;
    int          error_cnt = 0;
    int          compares = 0;
    int          txc = 0;
    int          tbase = 0;
    int          nfr = 0;

    // core clock and completion tally
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (tx_irq === 1'b1) txc <= txc + 1;

    actdm_engine i_actdm_engine (.mclk, .rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .bit_clk, .frame_sync, .sdata_in,
        .sdata_out, .rx_irq, .tx_irq, .rx_vector, .tx_vector);
    actdm_codec_model i_actdm_codec_model (.run, .sdata_out, .bit_clk,
        .frame_sync, .sdata_in, .pos, .txw);

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e,
                      input string nm);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, e);
    endtask
    task automatic wbuf(input int s, input logic [15:0] v);
        wr(actdm_pkg::A_TXBUF + 6'(s), v);
        tb_buf[s] = v;
    endtask
    task automatic wait_rx();
        int n;
        for (n = 0; n < 3000; n++) begin
            @(posedge mclk);
            #1;
            if (rx_irq === 1'b1) break;
        end
        nfr++;
        chk("rx request", {15'h0000, rx_irq}, 16'h0001);
        chk("rx bit", {8'h00, pos}, 16'h0050);
        // vector entry stands four cycles after the request
        repeat (4) @(posedge mclk);
        #1 chk("rx vector", {15'h0000, rx_vector}, 16'h0001);
    endtask
    task automatic wait_tx();
        int n;
        for (n = 0; n < 3000; n++) begin
            @(posedge mclk);
            #1;
            if (tx_irq === 1'b1) break;
        end
        chk("tx request", {15'h0000, tx_irq}, 16'h0001);
        repeat (4) @(posedge mclk);
        #1 chk("tx vector", {15'h0000, tx_vector}, 16'h0001);
    endtask
    task automatic slots(input logic [15:0] msk);
        for (int s = 0; s < 16; s++)
            chk("tx slot", txw[s], msk[s] ? tb_buf[s] : 16'h0000);
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        foreach (tb_buf[i]) tb_buf[i] = 16'h0000;
        tb_buf[0] = actdm_pkg::TAG_SETUP;
        tb_buf[1] = actdm_pkg::CFG_ADDR;
        tb_buf[2] = actdm_pkg::CFG_DATA;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(actdm_pkg::A_CTRL, 16'h0000, "control");
        rd(actdm_pkg::A_STATUS, 16'h0000, "status");
        rd(actdm_pkg::A_RXMASK, actdm_pkg::RX_MASK_RST, "rx mask");
        rd(actdm_pkg::A_TXMASK, actdm_pkg::TX_MASK_RST, "tx mask");
        for (int s = 0; s < 3; s++)
            rd(actdm_pkg::A_TXBUF + 6'(s), tb_buf[s], "tx buf");
        rd(6'h3f, 16'h0000, "unmapped");
        wbuf(3, 16'h1234);
        wbuf(4, 16'h5678);
        wbuf(6, 16'h6666);
        wbuf(15, 16'ha5a5);
        wr(actdm_pkg::A_CTRL, 16'h0007);
        run <= 1'b1;
        wait_rx();
        wait_rx();
        wr(actdm_pkg::A_TXBUF, 16'hf800);
        for (int s = 0; s < 5; s++) begin
            m = 16'h9000 ^ {4{4'(s)}};
            rd(actdm_pkg::A_RXBUF + 6'(s), m, "rx buf");
        end
        slots(actdm_pkg::TX_MASK_RST);
        wait_rx();
        chk("tag", txw[0], 16'he000);
        wait_rx();
        chk("tag", txw[0], 16'hf800);
        tb_buf[0] = 16'hf800;
        for (int i = 0; i < 2; i++) begin
            m = i ? actdm_pkg::TX16_MASK : actdm_pkg::TX7_MASK;
            run <= 1'b0;
            repeat (2100) @(posedge mclk);
            chk("tx done", 16'(txc - tbase), 16'(nfr));
            tbase = txc;
            nfr = 0;
            wr(actdm_pkg::A_TXMASK, m);
            rd(actdm_pkg::A_TXMASK, m, "tx mask");
            run <= 1'b1;
            wait_rx();
            wait_rx();
            slots(m);
        end
        wr(actdm_pkg::A_TXBUF, 16'hc000);
        wait_rx();
        chk("tag", txw[0], 16'hc000);
        // new tag built from the rx tag word, written after the tx request
        wait_tx();
        rd(actdm_pkg::A_RXBUF, 16'h9000, "rx tag");
        m = reg_rdata | actdm_pkg::TAG_SETUP;
        wr(actdm_pkg::A_TXBUF, m);
        wait_rx();
        chk("tag", txw[0], 16'hf000);
        end_of_test();
    end

    // hang guard
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule
